// ### hdl/catwl_pkg.sv
// Purpose: shared constants and carriers for the training / leveling block
// Assumes: 10-bit command/address bus, 16 data pins, two strobe byte lanes
// Notes:   all state and timing counts are named here once
package catwl_pkg;

  // ---------------------------------------------------------------
  // mode register addresses and operands
  // ---------------------------------------------------------------
  localparam logic [7:0] TRAINING_ENTRY_CMD_ADDR = 8'h29;
  localparam logic [7:0] TRAINING_ENTRY_CMD_OP   = 8'ha4;
  localparam logic [7:0] TRAINING_EXIT_CMD_ADDR  = 8'h2a;
  localparam logic [7:0] TRAINING_EXIT_CMD_OP    = 8'ha8;
  localparam logic [7:0] TRAINING_REMAP_CMD_ADDR = 8'h30;
  localparam logic [7:0] TRAINING_REMAP_CMD_OP   = 8'hc0;
  localparam logic [7:0] FEATURE2_ADDR           = 8'h02;
  localparam int         FEATURE2_WRLVL_BIT      = 7;
  localparam logic       WRLVL_RESET             = 1'b0;

  // ---------------------------------------------------------------
  // timing in ns and derived cycles at the 100 ns sample clock
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS           = 100;
  localparam int DATA_VALID_DELAY_NS       = 20;
  localparam int OUTPUT_RELEASE_DELAY_NS   = 20;
  localparam int LEVELING_OUTPUT_DELAY_NS  = 20;
  localparam int DATA_VALID_DELAY_CYC      =
    (DATA_VALID_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int OUTPUT_RELEASE_DELAY_CYC  =
    (OUTPUT_RELEASE_DELAY_NS / CLOCK_PERIOD_NS) < 1 ? 1
    : OUTPUT_RELEASE_DELAY_NS / CLOCK_PERIOD_NS;
  localparam int LEVELING_OUTPUT_DELAY_CYC =
    (LEVELING_OUTPUT_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DLY_W = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CATWL_IDLE  = 2'b00,
    CATWL_TRAIN = 2'b01,
    CATWL_REMAP = 2'b11,
    CATWL_WRLVL = 2'b10
  } catwl_mode_t;

  typedef struct packed {
    logic       cs_n;
    logic       cke;
    logic [9:0] ca;
  } catwl_cmd_t;

  typedef struct packed {
    logic [15:0] dq_o;
    logic [15:0] dq_oe_n;
    logic        dqs_oe_n;
  } catwl_pins_t;

endpackage : catwl_pkg

// ### hdl/catwl_sync.sv
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module catwl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } catwl_sync_t;

  catwl_sync_t st_r;
  catwl_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : catwl_sync

// ### hdl/catwl_top.sv
// Purpose: command/address training and write leveling feedback logic
// Assumes: link clock, command bus and strobes are sampled by a 10 MHz clock
// Notes:
// Notes on behaviour
// - write 0xA4 to address 0x29 enters training; same value on both edges.
// - first mapping returns CA0-3,5-8 rising on even DQ, falling on odd DQ.
// - write 0xC0 to 0x30 maps CA4 to DQ0/1 and CA9 to DQ8/9.
// - write 0xA8 to 0x2A leaves training; same value on both edges.
// - unused data pins driven valid; strobe never toggles while feeding back.
// - entry and exit writes decode correctly before bus timing is adjusted.
// - irregular clock periods with select high and enable low are tolerated.
// - feedback valid and release delays timed from true-clock falling edge.
// - repeated writes allowed; a select while feedback is pending does not restart the valid delay.
// - output release met after falling edge following first exit select.
// - feature register bit 7 high enters leveling, low leaves it.
// - data pins may be undefined on leveling entry.
// - strobe rising edge latches clock; result driven on its byte lane.
// - termination is off and its pin ignored during training.
`timescale 1ns/1ps
module catwl_top #(
  parameter int DV_CYC  = catwl_pkg::DATA_VALID_DELAY_CYC,
  parameter int REL_CYC = catwl_pkg::OUTPUT_RELEASE_DELAY_CYC,
  parameter int WLO_CYC = catwl_pkg::LEVELING_OUTPUT_DELAY_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        true_clock,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic [9:0]  command_address_bus,
  input  wire logic [1:0]  dqs_t,
  input  wire logic        odt_pin,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_oe_n,
  output logic             dqs_oe_n,
  output logic             odt_enable,
  output logic      [1:0]  mode
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [15:0] sy;

  catwl_sync #(.WIDTH(16)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .clk_en(clk_en),
    .d     ({true_clock, cke, cs_n, command_address_bus, dqs_t, odt_pin}),
    .q     (sy)
  );

  logic       s_ck;
  logic       s_cke;
  logic       s_cs_n;
  logic [9:0] s_ca;
  logic [1:0] s_dqs;
  logic       s_odt;

  assign {s_ck, s_cke, s_cs_n, s_ca, s_dqs, s_odt} = sy;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                  ck_d;
    logic [1:0]            dqs_d;
    catwl_pkg::catwl_mode_t md;
    logic                  cmd_pend;
    logic [9:0]            ca_rise;
    logic [9:0]            ca_fall;
    logic                  fb_pend;
    logic                  exit_pend;
    logic [catwl_pkg::DLY_W-1:0] dly;
    logic [catwl_pkg::DLY_W-1:0] rel;
    logic [1:0]            wl_smp;
    logic [1:0]            wl_vld;
    logic [catwl_pkg::DLY_W-1:0] wl_dly;
    catwl_pkg::catwl_pins_t pins;
    logic                  odt_en;
  } catwl_state_t;

  catwl_state_t st_r;
  catwl_state_t st_nxt;

  // command decode from rising and falling halves
  function automatic logic is_mrw(input logic [9:0] r);
    is_mrw = (r[3:0] == 4'h0);
  endfunction : is_mrw

  function automatic logic [7:0] mrw_addr(input logic [9:0] r, input logic [9:0] f);
    mrw_addr = {f[1:0], r[9:4]};
  endfunction : mrw_addr

  function automatic logic [7:0] mrw_op(input logic [9:0] f);
    mrw_op = f[9:2];
  endfunction : mrw_op

  function automatic logic [15:0] map_dq(input catwl_pkg::catwl_mode_t m,
                                         input logic [9:0] r, input logic [9:0] f);
    logic [15:0] v;
    v = '0;
    if (m == catwl_pkg::CATWL_REMAP) begin
      v[0] = r[4];
      v[1] = f[4];
      v[8] = r[9];
      v[9] = f[9];
    end else begin
      v = {f[8], r[8], f[7], r[7], f[6], r[6], f[5], r[5],
           f[3], r[3], f[2], r[2], f[1], r[1], f[0], r[0]};
    end
    map_dq = v;
  endfunction : map_dq

  logic       ck_rise;
  logic       ck_fall;
  logic [1:0] dqs_rise;
  logic [7:0] a;
  logic [7:0] op;

  assign ck_rise  = s_ck & ~st_r.ck_d;
  assign ck_fall  = ~s_ck & st_r.ck_d;
  assign dqs_rise = s_dqs & ~st_r.dqs_d;
  assign a        = mrw_addr(st_r.ca_rise, s_ca);
  assign op       = mrw_op(s_ca);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      st_nxt.ck_d  = s_ck;
      st_nxt.dqs_d = s_dqs;
      // rising edge: capture first half of a selected command
      if (ck_rise) begin
        st_nxt.cmd_pend = ~s_cs_n;
        st_nxt.ca_rise  = s_ca;
      end
      if (ck_fall && st_r.cmd_pend) begin
        st_nxt.cmd_pend = 1'b0;
        st_nxt.ca_fall  = s_ca;
        // each select in training or remap loads the valid delay, but a pending countdown below overrides the reload
        if (st_r.md == catwl_pkg::CATWL_TRAIN || st_r.md == catwl_pkg::CATWL_REMAP) begin
          st_nxt.fb_pend = 1'b1;
          st_nxt.dly     = catwl_pkg::DLY_W'(DV_CYC);
        end
        if (is_mrw(st_r.ca_rise)) begin
          // entry / exit use identical halves, decodable untrained
          if (a == catwl_pkg::TRAINING_ENTRY_CMD_ADDR
              && op == catwl_pkg::TRAINING_ENTRY_CMD_OP
              && st_r.md != catwl_pkg::CATWL_WRLVL) begin
            if (st_r.md == catwl_pkg::CATWL_IDLE) begin
              st_nxt.md = catwl_pkg::CATWL_TRAIN;
            end
            st_nxt.fb_pend = 1'b0;
          end else if (a == catwl_pkg::TRAINING_REMAP_CMD_ADDR
                       && op == catwl_pkg::TRAINING_REMAP_CMD_OP
                       && st_r.md != catwl_pkg::CATWL_IDLE
                       && st_r.md != catwl_pkg::CATWL_WRLVL) begin
            st_nxt.md      = catwl_pkg::CATWL_REMAP;
            st_nxt.fb_pend = 1'b0;
          end else if (a == catwl_pkg::TRAINING_EXIT_CMD_ADDR
                       && op == catwl_pkg::TRAINING_EXIT_CMD_OP
                       && st_r.md != catwl_pkg::CATWL_WRLVL
                       && st_r.md != catwl_pkg::CATWL_IDLE) begin
            // release counted from first exit select only
            st_nxt.fb_pend = 1'b0;
            if (!st_r.exit_pend) begin
              st_nxt.exit_pend = 1'b1;
              st_nxt.rel       = catwl_pkg::DLY_W'(REL_CYC);
            end
          end else if (a == catwl_pkg::FEATURE2_ADDR
                       && (st_r.md == catwl_pkg::CATWL_IDLE
                           || st_r.md == catwl_pkg::CATWL_WRLVL)) begin
            st_nxt.md = op[catwl_pkg::FEATURE2_WRLVL_BIT]
                        ? catwl_pkg::CATWL_WRLVL : catwl_pkg::CATWL_IDLE;
            st_nxt.wl_vld = '0;
          end
        end
      end
      // training feedback: data valid delay countdown
      if (st_r.fb_pend) begin
        if (st_r.dly <= catwl_pkg::DLY_W'(1)) begin
          st_nxt.fb_pend      = 1'b0;
          st_nxt.pins.dq_o    = map_dq(st_r.md, st_r.ca_rise, st_r.ca_fall);
          st_nxt.pins.dq_oe_n = '0;
        end else begin
          st_nxt.dly = st_r.dly - catwl_pkg::DLY_W'(1);
        end
      end
      // exit: release the data pins and return to idle
      if (st_r.exit_pend) begin
        if (st_r.rel <= catwl_pkg::DLY_W'(1)) begin
          st_nxt.exit_pend    = 1'b0;
          st_nxt.md           = catwl_pkg::CATWL_IDLE;
          st_nxt.pins.dq_oe_n = '1;
          st_nxt.fb_pend      = 1'b0;
        end else begin
          st_nxt.rel = st_r.rel - catwl_pkg::DLY_W'(1);
        end
      end
      // write leveling: strobe rising edge latches the clock level
      if (st_r.md == catwl_pkg::CATWL_WRLVL) begin
        for (int i = 0; i < 2; i++) begin
          if (dqs_rise[i]) begin
            st_nxt.wl_smp[i] = s_ck;
            st_nxt.wl_vld[i] = 1'b1;
            st_nxt.wl_dly    = catwl_pkg::DLY_W'(WLO_CYC);
          end
        end
        if (st_r.wl_dly != '0) begin
          st_nxt.wl_dly = st_r.wl_dly - catwl_pkg::DLY_W'(1);
        end else begin
          for (int i = 0; i < 2; i++) begin
            if (st_r.wl_vld[i]) begin
              st_nxt.pins.dq_o[i*8 +: 8]    = {8{st_r.wl_smp[i]}};
              st_nxt.pins.dq_oe_n[i*8 +: 8] = '0;
            end
          end
        end
      end
      // idle releases every data pin in the same cycle the mode drops
      if (st_nxt.md == catwl_pkg::CATWL_IDLE && !st_nxt.exit_pend) begin
        st_nxt.pins.dq_oe_n = '1;
        st_nxt.wl_vld       = '0;
      end
      // strobe stays undriven and static in every mode, leveling included
      st_nxt.pins.dqs_oe_n = 1'b1;
      // termination off in training, pin ignored
      st_nxt.odt_en = (st_nxt.md == catwl_pkg::CATWL_TRAIN
                       || st_nxt.md == catwl_pkg::CATWL_REMAP) ? 1'b0 : s_odt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r              <= '0;
      st_r.md           <= catwl_pkg::CATWL_IDLE;
      st_r.pins.dq_oe_n <= '1;
      st_r.pins.dqs_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dq_o       = st_r.pins.dq_o;
  assign dq_oe_n    = st_r.pins.dq_oe_n;
  assign dqs_oe_n   = st_r.pins.dqs_oe_n;
  assign odt_enable = st_r.odt_en;
  assign mode       = st_r.md;

endmodule : catwl_top

// ### testbench/catwl_ctrl_model.sv
// Purpose: behavioural memory controller for the link side
// Assumes: tasks are started just after a clock edge
// Notes:   link clock stands low between frames
`timescale 1ns/1ps
module catwl_ctrl_model (
  output logic       true_clock,
  output logic       cke,
  output logic       cs_n,
  output logic [9:0] command_address_bus,
  output logic [1:0] dqs_t
);
  initial begin
    true_clock = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    command_address_bus = 10'h155;
    dqs_t = 2'b00;
  end
  task automatic send(input logic [9:0] r, input logic [9:0] f);
    command_address_bus = r;
    cs_n = 1'b0;
    #200 true_clock = 1'b1;
    #200 command_address_bus = f;
    #200 true_clock = 1'b0;
    #200 cs_n = 1'b1;
    command_address_bus = ~f;
  endtask : send
  task automatic mode_register_write(input logic [7:0] a, input logic [7:0] op);
    send({a[5:0], 4'h0}, {op, a[7:6]});
  endtask : mode_register_write
  task automatic glitch();
    cke = 1'b0;
    #130 true_clock = 1'b1;
    #70 true_clock = 1'b0;
    #310 true_clock = 1'b1;
    #290 true_clock = 1'b0;
    cke = 1'b1;
  endtask : glitch
  task automatic wl_pulse(input int ln, input int k);
    fork
      #400 true_clock = 1'b1;
      #(k * 100) dqs_t[ln] = 1'b1;
    join
    #400 dqs_t[ln] = 1'b0;
    true_clock = 1'b0;
  endtask : wl_pulse
endmodule : catwl_ctrl_model

// ### testbench/catwl_top_bench.sv
// Purpose: self-checking bench for training and leveling
// Assumes: default one-cycle delays of the design
// Notes:   expected feedback comes from exp_fb
`timescale 1ns/1ps
module catwl_top_bench;
  logic        clock, rst_n, clk_en, odt_pin;
  logic        true_clock, cke, cs_n, dqs_oe_n, odt_enable;
  logic [9:0]  ca, r, f;
  logic [1:0]  dqs_t, mode;
  logic [15:0] dq_o, dq_oe_n, e;
  int          miscompares, check_count, seed;
  catwl_ctrl_model m (.true_clock(true_clock), .cke(cke), .cs_n(cs_n),
    .command_address_bus(ca), .dqs_t(dqs_t));
  catwl_top catwl_top_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .true_clock(true_clock), .cke(cke), .cs_n(cs_n), .command_address_bus(ca),
    .dqs_t(dqs_t), .odt_pin(odt_pin), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .dqs_oe_n(dqs_oe_n), .odt_enable(odt_enable), .mode(mode));
  function automatic logic [15:0] exp_fb(input logic rm, input logic [9:0] r, f);
    int          idx [8] = '{0, 1, 2, 3, 5, 6, 7, 8};
    logic [15:0] x = 16'h0000;
    if (rm) return {6'h00, f[9], r[9], 6'h00, f[4], r[4]};
    for (int k = 0; k < 8; k++) x[2*k +: 2] = {f[idx[k]], r[idx[k]]};
    return x;
  endfunction : exp_fb
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    seed = 40888;
    rst_n = 1'b0;
    clk_en = 1'b1;
    odt_pin = 1'b1;
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    tick(5);
    check(dq_oe_n, 16'hffff);
    m.mode_register_write(8'h29, 8'ha4);
    tick(5);
    check({14'h0000, mode}, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) begin
        m.mode_register_write(8'h30, 8'hc0);
        tick(5);
        check({14'h0000, mode}, 16'h0003);
      end
      r = i == 0 ? 10'h3ff : 10'($random(seed));
      f = i == 0 ? 10'h000 : 10'($random(seed));
      odt_pin = 1'($random(seed));
      if (r[3:0] == 4'h0) r[0] = 1'b1;
      if (i == 1) m.send(10'h2aa, 10'h155);
      m.send(r, f);
      tick(5);
      e = exp_fb(i >= 6, r, f);
      check(dq_o, e);
      check(dq_oe_n, 16'h0000);
      check({15'h0000, odt_enable}, 16'h0000);
    end
    m.mode_register_write(8'h02, 8'h80);
    // the refused write is still a selected command, so it is fed back
    e = exp_fb(1'b1, 10'h020, 10'h200);
    m.glitch();
    tick(5);
    check({14'h0000, mode}, 16'h0003);
    check(dq_o, e);
    m.mode_register_write(8'h2a, 8'ha8);
    tick(5);
    check({14'h0000, mode}, 16'h0000);
    check(dq_oe_n, 16'hffff);
    m.mode_register_write(8'h30, 8'hc0);
    tick(5);
    check({14'h0000, mode}, 16'h0000);
    $display("training test done");
    m.mode_register_write(8'h02, 8'h80);
    tick(5);
    check({14'h0000, mode}, 16'h0002);
    for (int ln = 0; ln < 2; ln++)
      for (int k = 1; k < 8; k++) begin
        if (k == 4) continue;
        m.wl_pulse(ln, k);
        tick(8);
        check({8'h00, dq_o[ln*8 +: 8]}, k > 4 ? 16'h00ff : 16'h0000);
        check({8'h00, dq_oe_n[ln*8 +: 8]}, 16'h0000);
      end
    m.mode_register_write(8'h02, 8'h00);
    tick(5);
    check({14'h0000, mode}, 16'h0000);
    check(dq_oe_n, 16'hffff);
    $display("leveling test done");
    tally_and_finish();
  end
endmodule : catwl_top_bench

// ### testbench/catwl_top_monitor.sv
// Purpose: port checks for the training and leveling block
// Assumes: clk_en held high by the bench
// Notes:   mode 01/11 training, 10 leveling, 00 idle
`timescale 1ns/1ps
module catwl_top_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [1:0]  dqs_t,
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe_n,
  input wire logic        dqs_oe_n,
  input wire logic        odt_enable,
  input wire logic [1:0]  mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_quiet; dqs_oe_n == 1'b1; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe driven");
  property p_odt; mode[0] && $past(mode[0]) |-> !odt_enable; endproperty
  a_odt: assert property (p_odt) else $error("odt on in training");
  property p_idle; mode == 2'b00 |-> dq_oe_n == 16'hffff; endproperty
  a_idle: assert property (p_idle) else $error("dq driven in idle");
  property p_all; mode[0] && !dq_oe_n[0] |-> dq_oe_n == 16'h0000; endproperty
  a_all: assert property (p_all) else $error("unused dq undriven");
  property p_lane; mode == 2'b10 && !dq_oe_n[0]
    |-> dq_o[7:0] inside {8'h00, 8'hff} && dq_oe_n[7:0] == 8'h00; endproperty
  a_lane: assert property (p_lane) else $error("lane not uniform");
  property p_nowl; $past(mode[0]) |-> mode != 2'b10; endproperty
  a_nowl: assert property (p_nowl) else $error("leveling from training");
  property p_ent; mode == 2'b01 && $past(mode) != 2'b01 |-> $past(mode) != 2'b10; endproperty
  a_ent: assert property (p_ent) else $error("entry in leveling");
  property p_remap; mode == 2'b11 && $past(mode) != 2'b11 |-> $past(mode) == 2'b01;
  endproperty
  a_remap: assert property (p_remap) else $error("remap outside training");
  property p_wlo; (mode == 2'b10 && $rose(dqs_t[0])) ##1 (mode == 2'b10) [*7]
    |-> dq_oe_n[7:0] == 8'h00; endproperty
  a_wlo: assert property (p_wlo) else $error("no leveling answer");
endmodule : catwl_top_chk
bind catwl_top catwl_top_chk catwl_top_chk_i (
  .clock      (clock),
  .rst_n      (rst_n),
  .dqs_t      (dqs_t),
  .dq_o       (dq_o),
  .dq_oe_n    (dq_oe_n),
  .dqs_oe_n   (dqs_oe_n),
  .odt_enable (odt_enable),
  .mode       (mode)
);
